// ==== inc/tpt_regs.vh ====
// register offsets, field positions, reset values and timing counts of the timed poll master
// assumes byte addressing on a 14-bit plain register port, one 32-bit word per register
`ifndef TPT_REGS_VH
`define TPT_REGS_VH
`define TPT_CTRL_OFS 14'h0000
`define TPT_INTERVAL_OFS 14'h0004
`define TPT_ROUTE_OFS 14'h0008
`define TPT_ROUTE_LEN_OFS 14'h000c
`define TPT_RD_COUNT_OFS 14'h0010
`define TPT_RD_FROM_OFS 14'h0014
`define TPT_RD_TO_OFS 14'h0018
`define TPT_WR_COUNT_OFS 14'h001c
`define TPT_WR_FROM_OFS 14'h0020
`define TPT_WR_TO_OFS 14'h0024
`define TPT_STATUS_OFS 14'h0028
`define TPT_MBOX_BIT 13
`define TPT_CTRL_NATIVE_BIT 0
`define TPT_CTRL_REGPROTO_BIT 1
`define TPT_CTRL_ONETH_BIT 2
`define TPT_CTRL_PEER_BIT 3
`define TPT_ST_ENABLED_BIT 0
`define TPT_ST_OUTSTANDING_BIT 1
`define TPT_ST_PENALTY_BIT 2
`define TPT_ST_NEXTWR_BIT 3
`define TPT_ST_RDEN_BIT 4
`define TPT_ST_WREN_BIT 5
`define TPT_ST_LASTERR_BIT 6
`define TPT_ST_BUSY_BIT 7
`define TPT_RST_CTRL 4'h0
`define TPT_RST_INTERVAL 16'h0000
`define TPT_RST_ROUTE 32'h00000000
`define TPT_RST_ROUTE_LEN 3'h0
`define TPT_RST_COUNT 8'h00
`define TPT_RST_ADDR 16'h0000
`define TPT_MAX_COUNT 8'h80
`define TPT_MBOX_MIN 16'h0001
`define TPT_MBOX_MAX 16'h0800
`define TPT_CLK_NS 10
`define TPT_TICK_NS 10000000
`define TPT_TICK_MS 10
`define TPT_PENALTY_MS 2000
`define TPT_PENALTY_TICKS (`TPT_PENALTY_MS / `TPT_TICK_MS)
`endif

// ==== rtl/tpt_mailbox_ram.v ====
// mailbox register array: two independent ports, each with a registered read
// assumes callers never write the same word from both ports in one cycle
module tpt_mailbox_ram #(
   parameter AW = 11,
   parameter DW = 16
) (
   input wire core_clk, // system clock
   input wire [AW-1:0] aAddr, // port a word index
   input wire aWrite, // port a write strobe
   input wire [DW-1:0] aWdata, // port a write data
   output reg [DW-1:0] aRdata, // port a read data, one cycle after address
   input wire [AW-1:0] bAddr, // port b word index
   input wire bWrite, // port b write strobe
   input wire [DW-1:0] bWdata, // port b write data
   output reg [DW-1:0] bRdata // port b read data, one cycle after address
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // no reset on the array so it maps to block memory
   always @(posedge core_clk) begin
      if (aWrite) begin
         mem[aAddr] <= aWdata;
      end
      aRdata <= mem[aAddr];
   end

   always @(posedge core_clk) begin
      if (bWrite) begin
         mem[bAddr] <= bWdata;
      end
      bRdata <= mem[bAddr];
   end
endmodule

// ==== rtl/tpt_tick_gen.v ====
// base tick generator: one-cycle pulse every TICK_CYCLES clocks
// assumes a free-running core clock
module tpt_tick_gen #(
   parameter TICK_CYCLES = 1000000,
   parameter CW = 20
) (
   input wire core_clk, // system clock
   input wire reset_n, // asynchronous reset, active low
   output reg tick // one-cycle pulse per tick period
);
   localparam integer LAST_INT = TICK_CYCLES - 1;
   localparam [CW-1:0] LAST = LAST_INT[CW-1:0];
   reg [CW-1:0] cnt;

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= {CW{1'b0}};
         tick <= 1'b0;
      end else if (cnt == LAST) begin
         cnt <= {CW{1'b0}};
         tick <= 1'b1;
      end else begin
         cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
         tick <= 1'b0;
      end
   end
endmodule

// ==== rtl/tpt_poll_master.v ====
// timed poll master for one port: originates one read and/or one write to a single route
// assumes a message engine on the same clock that takes requests, streams data and reports replies
`include "tpt_regs.vh"
module tpt_poll_master #(
   parameter TICK_CYCLES = `TPT_TICK_NS / `TPT_CLK_NS,
   parameter TICK_CW = 20
) (
   input wire core_clk, // system clock, 100 MHz
   input wire reset_n, // asynchronous reset, active low
   input wire [13:0] busAddr, // register byte address
   input wire [31:0] busWdata, // register write data
   input wire busWrite, // write strobe
   input wire busRead, // read strobe
   output wire [31:0] busRdata, // read data, cycle after read strobe
   output wire portIsMaster, // port acts as bus master, slave answers off
   output wire reqValid, // request to message engine
   input wire reqReady, // engine takes request
   output reg reqIsWrite, // request is a write
   output reg [31:0] reqRoute, // route drops, first drop in low byte
   output reg [2:0] reqRouteLen, // number of route drops
   output reg [15:0] reqRemoteAddr, // first register in remote device
   output reg [7:0] reqCount, // register count
   output reg [15:0] txData, // write data word
   output reg txValid, // write data valid
   input wire txReady, // engine takes write word
   input wire [15:0] rxData, // read reply word
   input wire rxValid, // read reply word valid
   input wire replyDone, // reply finished, one-cycle pulse
   input wire replyError // reply failed, beside replyDone
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_REQ = 3'h1;
   localparam [2:0] ST_WFETCH = 3'h2;
   localparam [2:0] ST_WLOAD = 3'h3;
   localparam [2:0] ST_WSEND = 3'h4;
   localparam integer PENALTY_INT = `TPT_PENALTY_TICKS;
   localparam [7:0] PENALTY = PENALTY_INT[7:0];

   reg [3:0] ctrl;
   reg [15:0] interval;
   reg [31:0] route;
   reg [2:0] routeLen;
   reg [7:0] rdCount;
   reg [15:0] rdFrom;
   reg [15:0] rdTo;
   reg [7:0] wrCount;
   reg [15:0] wrFrom;
   reg [15:0] wrTo;
   reg [31:0] csrRdata;
   reg mboxRdSel;
   reg [2:0] state;
   reg [15:0] intervalCnt;
   reg [7:0] penaltyCnt;
   reg due;
   reg outstanding;
   reg curIsRead;
   reg nextIsWrite;
   reg lastErr;
   reg [7:0] xferIdx;
   reg [15:0] portBAddr;
   reg [31:0] next_csrRdata;

   wire tick;
   wire [15:0] mboxAData;
   wire [15:0] mboxBData;
   wire csrHit = ~busAddr[`TPT_MBOX_BIT];
   wire [13:0] csrAddr = {busAddr[13:2], 2'b00};

   wire fnEnable = (interval != 16'h0000) && !(ctrl[`TPT_CTRL_ONETH_BIT] && ctrl[`TPT_CTRL_PEER_BIT]);
   wire rdCountOk = (rdCount != 8'h00) && (!ctrl[`TPT_CTRL_NATIVE_BIT] || rdCount <= `TPT_MAX_COUNT);
   wire rdToOk = (rdTo >= `TPT_MBOX_MIN) && (rdTo <= `TPT_MBOX_MAX);
   wire readEn = rdCountOk && rdToOk;
   wire wrFromOk = (wrFrom >= `TPT_MBOX_MIN) && (wrFrom <= `TPT_MBOX_MAX);
   wire writeEn = (wrCount != 8'h00) && (wrCount <= `TPT_MAX_COUNT) && wrFromOk;
   wire bothEn = readEn && writeEn;
   wire anyEn = readEn || writeEn;
   wire expire = tick && fnEnable && ((intervalCnt + 16'h0001) >= interval);
   wire launch = (state == ST_IDLE) && due && !outstanding && (penaltyCnt == 8'h00) && fnEnable && anyEn;
   wire launchWrite = bothEn ? nextIsWrite : writeEn;

   // reply words beyond the count or past the mailbox end are dropped
   wire [16:0] rxReg = {1'b0, rdTo} + {9'h000, xferIdx};
   wire rxStore = rxValid && outstanding && curIsRead && (xferIdx < reqCount) && (rxReg <= {1'b0, `TPT_MBOX_MAX});
   wire [15:0] rxIndex = rxReg[15:0] - 16'h0001;
   wire [15:0] txIndex = wrFrom - 16'h0001 + {8'h00, xferIdx};

   assign portIsMaster = fnEnable && anyEn && ctrl[`TPT_CTRL_REGPROTO_BIT];
   assign reqValid = (state == ST_REQ);
   assign busRdata = mboxRdSel ? {16'h0000, mboxAData} : csrRdata;

   tpt_tick_gen #(
      .TICK_CYCLES(TICK_CYCLES),
      .CW(TICK_CW)
   ) u_tick (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .tick(tick)
   );

   tpt_mailbox_ram #(
      .AW(11),
      .DW(16)
   ) u_mbox (
      .core_clk(core_clk),
      .aAddr(busAddr[12:2]),
      .aWrite(busWrite && !csrHit),
      .aWdata(busWdata[15:0]),
      .aRdata(mboxAData),
      .bAddr(portBAddr[10:0]),
      .bWrite(rxStore),
      .bWdata(rxData),
      .bRdata(mboxBData)
   );

   always @* begin
      portBAddr = (state == ST_WFETCH) ? txIndex : rxIndex;
   end

   always @* begin
      next_csrRdata = 32'h00000000;
      case (csrAddr)
         `TPT_CTRL_OFS: next_csrRdata = {28'h0000000, ctrl};
         `TPT_INTERVAL_OFS: next_csrRdata = {16'h0000, interval};
         `TPT_ROUTE_OFS: next_csrRdata = route;
         `TPT_ROUTE_LEN_OFS: next_csrRdata = {29'h00000000, routeLen};
         `TPT_RD_COUNT_OFS: next_csrRdata = {24'h000000, rdCount};
         `TPT_RD_FROM_OFS: next_csrRdata = {16'h0000, rdFrom};
         `TPT_RD_TO_OFS: next_csrRdata = {16'h0000, rdTo};
         `TPT_WR_COUNT_OFS: next_csrRdata = {24'h000000, wrCount};
         `TPT_WR_FROM_OFS: next_csrRdata = {16'h0000, wrFrom};
         `TPT_WR_TO_OFS: next_csrRdata = {16'h0000, wrTo};
         `TPT_STATUS_OFS: next_csrRdata = {24'h000000, (state != ST_IDLE), lastErr, writeEn, readEn,
                                          nextIsWrite, (penaltyCnt != 8'h00), outstanding, fnEnable};
         default: next_csrRdata = 32'h00000000;
      endcase
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= `TPT_RST_CTRL;
         interval <= `TPT_RST_INTERVAL;
         route <= `TPT_RST_ROUTE;
         routeLen <= `TPT_RST_ROUTE_LEN;
         rdCount <= `TPT_RST_COUNT;
         rdFrom <= `TPT_RST_ADDR;
         rdTo <= `TPT_RST_ADDR;
         wrCount <= `TPT_RST_COUNT;
         wrFrom <= `TPT_RST_ADDR;
         wrTo <= `TPT_RST_ADDR;
         csrRdata <= 32'h00000000;
         mboxRdSel <= 1'b0;
      end else begin
         mboxRdSel <= busRead && !csrHit;
         csrRdata <= (busRead && csrHit) ? next_csrRdata : 32'h00000000;
         if (busWrite && csrHit) begin
            case (csrAddr)
               `TPT_CTRL_OFS: ctrl <= busWdata[3:0];
               `TPT_INTERVAL_OFS: interval <= busWdata[15:0];
               `TPT_ROUTE_OFS: route <= busWdata;
               `TPT_ROUTE_LEN_OFS: routeLen <= busWdata[2:0];
               `TPT_RD_COUNT_OFS: rdCount <= busWdata[7:0];
               `TPT_RD_FROM_OFS: rdFrom <= busWdata[15:0];
               `TPT_RD_TO_OFS: rdTo <= busWdata[15:0];
               `TPT_WR_COUNT_OFS: wrCount <= busWdata[7:0];
               `TPT_WR_FROM_OFS: wrFrom <= busWdata[15:0];
               `TPT_WR_TO_OFS: wrTo <= busWdata[15:0];
               default: ctrl <= ctrl;
            endcase
         end
      end
   end

   // interval pacing and the late-reply penalty
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         intervalCnt <= 16'h0000;
         penaltyCnt <= 8'h00;
         due <= 1'b0;
      end else if (!fnEnable || !anyEn) begin
         intervalCnt <= 16'h0000;
         penaltyCnt <= 8'h00;
         due <= 1'b0;
      end else begin
         if (expire) begin
            intervalCnt <= 16'h0000;
         end else if (tick) begin
            intervalCnt <= intervalCnt + 16'h0001;
         end
         // a penalty armed by this expiry wins over the countdown
         if (expire && (outstanding || state != ST_IDLE)) begin
            penaltyCnt <= PENALTY;
         end else if (tick && penaltyCnt != 8'h00) begin
            penaltyCnt <= penaltyCnt - 8'h01;
         end
         if (expire) begin
            due <= 1'b1;
         end else if (launch) begin
            due <= 1'b0;
         end
      end
   end

   // transfer sequencer
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         outstanding <= 1'b0;
         curIsRead <= 1'b0;
         nextIsWrite <= 1'b0;
         lastErr <= 1'b0;
         xferIdx <= 8'h00;
         reqIsWrite <= 1'b0;
         reqRoute <= 32'h00000000;
         reqRouteLen <= 3'h0;
         reqRemoteAddr <= 16'h0000;
         reqCount <= 8'h00;
         txData <= 16'h0000;
         txValid <= 1'b0;
      end else begin
         if (replyDone && outstanding) begin
            lastErr <= replyError;
         end
         if (rxStore) begin
            xferIdx <= xferIdx + 8'h01;
         end
         if (!fnEnable) begin
            nextIsWrite <= 1'b0;
         end
         case (state)
            ST_IDLE: begin
               if (replyDone) begin
                  outstanding <= 1'b0;
               end
               if (launch) begin
                  reqIsWrite <= launchWrite;
                  reqRoute <= route;
                  reqRouteLen <= routeLen;
                  reqRemoteAddr <= launchWrite ? wrTo : rdFrom;
                  reqCount <= launchWrite ? wrCount : rdCount;
                  curIsRead <= !launchWrite;
                  nextIsWrite <= bothEn ? !launchWrite : 1'b0;
                  xferIdx <= 8'h00;
                  state <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (reqReady) begin
                  outstanding <= 1'b1;
                  state <= reqIsWrite ? ST_WFETCH : ST_IDLE;
               end
            end
            ST_WFETCH: begin
               if (replyDone) begin
                  outstanding <= 1'b0;
               end
               state <= ST_WLOAD;
            end
            ST_WLOAD: begin
               if (replyDone) begin
                  outstanding <= 1'b0;
               end
               txData <= mboxBData;
               txValid <= 1'b1;
               state <= ST_WSEND;
            end
            ST_WSEND: begin
               if (replyDone) begin
                  outstanding <= 1'b0;
               end
               if (txReady) begin
                  txValid <= 1'b0;
                  xferIdx <= xferIdx + 8'h01;
                  state <= ((xferIdx + 8'h01) == reqCount) ? ST_IDLE : ST_WFETCH;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// ==== test/tpt_poll_master_properties.sv ====
// port assertions for the timed poll master
// assumes one clock and the register offsets of tpt_regs.vh
`include "tpt_regs.vh"
module tpt_poll_master_properties #(
   parameter TICK_CYCLES = 10,
   parameter TICK_CW = 20
) (
   input wire core_clk, // clock
   input wire reset_n, // reset, low
   input wire [13:0] busAddr, // address
   input wire [31:0] busWdata, // write data
   input wire busWrite, // write strobe
   input wire portIsMaster, // master mode
   input wire reqValid, // request
   input wire reqReady, // taken
   input wire reqIsWrite, // write request
   input wire [31:0] reqRoute, // route
   input wire [15:0] reqRemoteAddr, // remote start
   input wire [7:0] reqCount, // count
   input wire [15:0] txData, // write word
   input wire txValid, // word valid
   input wire txReady // word taken
);
   logic [3:0] ctl;
   logic [15:0] intv;
   // mirrors of two of the registers that gate launching
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl <= `TPT_RST_CTRL;
         intv <= `TPT_RST_INTERVAL;
      end else if (busWrite && busAddr == `TPT_CTRL_OFS) begin
         ctl <= busWdata[3:0];
      end else if (busWrite && busAddr == `TPT_INTERVAL_OFS) begin
         intv <= busWdata[15:0];
      end
   end
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   a_req_held: assert property (reqValid && !reqReady
      |=> reqValid && $stable({reqIsWrite, reqRoute, reqRemoteAddr, reqCount})) else $error("request changed early");
   a_tx_held: assert property (txValid && !txReady
      |=> txValid && $stable(txData)) else $error("write word changed early");
   a_tx_after_wr: assert property (reqValid && reqReady && reqIsWrite
      |=> !txValid ##1 !txValid ##1 txValid) else $error("first write word late");
   a_read_no_tx: assert property (reqValid && !reqIsWrite |-> !txValid) else $error("word sent on read");
   a_zero_idle: assert property ((intv == 16'h0000)[*8]
      |-> !reqValid) else $error("request with zero interval");
   a_peer_idle: assert property ((ctl[2] && ctl[3])[*8]
      |-> !reqValid && !portIsMaster) else $error("request while peer on");
   a_rd_count: assert property (reqValid && !reqIsWrite
      |-> reqCount != 8'h00 && (!ctl[0] || reqCount <= 8'h80)) else $error("bad read count");
   a_wr_count: assert property (reqValid && reqIsWrite
      |-> reqCount != 8'h00 && reqCount <= 8'h80) else $error("bad write count");
   a_master_mode: assert property (portIsMaster
      |-> ctl[1] && intv != 16'h0000 && !(ctl[2] && ctl[3])) else $error("master mode wrong");
endmodule
bind tpt_poll_master tpt_poll_master_properties #(.TICK_CYCLES(TICK_CYCLES), .TICK_CW(TICK_CW)) i_props (
   .core_clk(core_clk), .reset_n(reset_n), .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite),
   .portIsMaster(portIsMaster), .reqValid(reqValid), .reqReady(reqReady), .reqIsWrite(reqIsWrite),
   .reqRoute(reqRoute), .reqRemoteAddr(reqRemoteAddr), .reqCount(reqCount), .txData(txData),
   .txValid(txValid), .txReady(txReady));

// ==== test/tpt_remote_slave.sv ====
// far-side model: message engine and remote slave answering the poll master
// assumes requests, write words and replies all run on the master's clock
module tpt_remote_slave (
   input wire core_clk, // clock
   input wire reset_n, // reset, low
   input wire slow, // late reply
   input wire reqValid, // request
   output logic reqReady, // taken
   input wire reqIsWrite, // write request
   input wire [15:0] reqRemoteAddr, // remote start
   input wire [7:0] reqCount, // count
   input wire txValid, // word valid
   output logic txReady, // word taken
   output logic [15:0] rxData, // reply word
   output logic rxValid, // reply valid
   output logic replyDone, // reply end
   output logic replyError // reply failed
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] a;
   int n;
   logic w;
   initial begin
      reqReady = 1'b0;
      txReady = 1'b0;
      rxValid = 1'b0;
      rxData = 16'h0000;
      replyDone = 1'b0;
      replyError = 1'b0;
      forever begin
         @(posedge core_clk);
         if (reset_n && reqValid) begin
            a = reqRemoteAddr;
            n = reqCount;
            w = reqIsWrite;
            reqReady <= 1'b1;
            @(posedge core_clk);
            reqReady <= 1'b0;
            txReady <= w;
            for (int k = 0; k < n; k++) begin
               if (w && (k % 2 == 1)) begin
                  // every other word is held off so the master must keep it standing
                  txReady <= 1'b0;
                  do @(posedge core_clk); while (!txValid);
                  txReady <= 1'b1;
                  @(posedge core_clk);
               end else if (w) begin
                  do @(posedge core_clk); while (!txValid);
               end else begin
                  rxValid <= 1'b1;
                  rxData <= a + 16'(k) ^ 16'h5a5a;
                  @(posedge core_clk);
               end
            end
            txReady <= 1'b0;
            rxValid <= 1'b0;
            // released data line must not keep the last word
            rxData <= ~rxData;
            if (slow) repeat (1600) @(posedge core_clk);
            replyDone <= 1'b1;
            @(posedge core_clk);
            replyDone <= 1'b0;
         end
      end
   end
endmodule

// ==== test/tpt_poll_master_tb.sv ====
// self-checking bench for the timed poll master with a far-side slave model
// assumes a 10-cycle tick so intervals and the late-reply delay stay short
`include "tpt_regs.vh"
module tpt_poll_master_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 10;
   localparam int IV = 150;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [13:0] busAddr = 14'h0000;
   logic [31:0] busWdata = 32'h00000000;
   logic busWrite = 1'b0;
   logic busRead = 1'b0;
   logic slow = 1'b0;
   wire [31:0] busRdata, reqRoute;
   wire [15:0] reqRemoteAddr, txData, rxData;
   wire [7:0] reqCount;
   wire [2:0] reqRouteLen;
   wire portIsMaster, reqValid, reqReady, reqIsWrite, txValid, txReady, rxValid, replyDone, replyError;
   int failures = 0;
   int checked = 0;
   int seed = 66;
   logic [59:0] rq[$];
   longint t[$];
   logic [15:0] tw[$];
   logic [15:0] mb[0:127];
   always #5 core_clk = ~core_clk;
   tpt_poll_master #(.TICK_CYCLES(TK)) i_tpt_poll_master (.core_clk(core_clk), .reset_n(reset_n),
      .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata),
      .portIsMaster(portIsMaster), .reqValid(reqValid), .reqReady(reqReady), .reqIsWrite(reqIsWrite),
      .reqRoute(reqRoute), .reqRouteLen(reqRouteLen), .reqRemoteAddr(reqRemoteAddr), .reqCount(reqCount),
      .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
      .replyDone(replyDone), .replyError(replyError));
   tpt_remote_slave i_tpt_remote_slave (.core_clk(core_clk), .reset_n(reset_n), .slow(slow),
      .reqValid(reqValid), .reqReady(reqReady), .reqIsWrite(reqIsWrite), .reqRemoteAddr(reqRemoteAddr),
      .reqCount(reqCount), .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
      .replyDone(replyDone), .replyError(replyError));
   always @(posedge core_clk) begin
      if (reqValid && reqReady) begin
         rq.push_back({reqIsWrite, reqRoute, reqRouteLen, reqRemoteAddr, reqCount});
         t.push_back($time / 10);
      end
      if (txValid && txReady) tw.push_back(txData);
   end
   task automatic give_verdict;
      if (failures == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one idle cycle after each strobe keeps every strobe a single clean pulse
   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      busAddr <= a;
      busWdata <= d;
      busWrite <= 1'b1;
      @(posedge core_clk);
      busWrite <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input string nm, input logic [13:0] a, input logic [31:0] e);
      busAddr <= a;
      busRead <= 1'b1;
      @(posedge core_clk);
      busRead <= 1'b0;
      #1;
      chk(nm, e, busRdata);
      @(posedge core_clk);
   endtask
   function automatic logic [13:0] ma(input logic [31:0] r);
      return 14'h2000 | 14'((r - 1) << 2);
   endfunction
   task automatic wait_req(input int n);
      for (int k = 0; k < 30000 && rq.size() < n; k++) @(posedge core_clk);
      if (rq.size() < n) begin
         failures++;
         $display("Error requests expected %0d seen %0d", n, rq.size());
         give_verdict();
      end
   endtask
   task automatic round(input logic [31:0] rc, input logic [31:0] rt, input logic [31:0] wc, input int nq);
      logic [31:0] rf, wf, wt, route;
      logic w;
      rf = 1 + {$random(seed)} % 65535;
      // reads land below 1024 in any round with writes, and writes come from 1024 up, so a read never alters words still to be sent
      wf = 1024 + {$random(seed)} % 768;
      wt = 1 + {$random(seed)} % 65535;
      route = {16'h0000, 8'($random(seed)), 8'h7d};
      wr(`TPT_INTERVAL_OFS, 32'h0);
      wr(`TPT_CTRL_OFS, 32'h3);
      wr(`TPT_ROUTE_OFS, route);
      wr(`TPT_ROUTE_LEN_OFS, 32'h2);
      wr(`TPT_RD_COUNT_OFS, rc);
      wr(`TPT_RD_FROM_OFS, rf);
      wr(`TPT_RD_TO_OFS, rt);
      wr(`TPT_WR_COUNT_OFS, wc);
      wr(`TPT_WR_FROM_OFS, wf);
      wr(`TPT_WR_TO_OFS, wt);
      for (int k = 0; k < wc; k++) begin
         mb[k] = 16'($random(seed));
         wr(ma(wf + k), {16'h0000, mb[k]});
      end
      rq.delete();
      t.delete();
      tw.delete();
      wr(`TPT_INTERVAL_OFS, IV);
      wait_req(nq);
      repeat (700) @(posedge core_clk);
      chk("master", 1, portIsMaster);
      for (int k = 0; k < nq; k++) begin
         w = rc == 0 || (wc != 0 && k % 2 == 1);
         chk("direction", w, rq[k][59]);
         chk("route", route, rq[k][58:27]);
         chk("route length", 2, rq[k][26:24]);
         chk("remote address", w ? wt : rf, rq[k][23:8]);
         chk("count", w ? wc : rc, rq[k][7:0]);
         if (k > 0) chk("spacing", IV * TK, t[k] - t[k - 1]);
      end
      chk("write words", (wc == 0 ? 0 : (rc == 0 ? nq : nq / 2)) * wc, tw.size());
      for (int k = 0; k < tw.size(); k++) chk("write word", mb[k % wc], tw[k]);
      for (int k = 0; k < rc; k++) rd("mailbox", ma(rt + k), 16'(rf + k) ^ 16'h5a5a);
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      rd("status", `TPT_STATUS_OFS, 32'h0);
      rd("interval", `TPT_INTERVAL_OFS, `TPT_RST_INTERVAL);
      wr(14'h0030, 32'hffffffff);
      rd("unmapped", 14'h0030, 32'h0);
      round(1 + {$random(seed)} % 32, 1 + {$random(seed)} % 990, 1 + {$random(seed)} % 32, 4);
      round(128, 2048 - 127, 0, 2);
      round(0, 5, 128, 2);
      slow <= 1'b1;
      rq.delete();
      t.delete();
      wait_req(2);
      chk("late gap", (IV + `TPT_PENALTY_TICKS) * TK, t[1] - t[0]);
      slow <= 1'b0;
      wr(`TPT_CTRL_OFS, 32'hf);
      rq.delete();
      repeat (4000) @(posedge core_clk);
      chk("peer requests", 0, rq.size());
      chk("peer master", 0, portIsMaster);
      wr(`TPT_CTRL_OFS, 32'h3);
      wr(`TPT_INTERVAL_OFS, 32'h0);
      rq.delete();
      repeat (4000) @(posedge core_clk);
      chk("idle requests", 0, rq.size());
      chk("idle master", 0, portIsMaster);
      give_verdict();
   end
endmodule
